// ===== src/uart_rx_fifo_wakeup.sv
// Receive side of one serial channel: 1x receiver, eight-entry queue with
// per-character status, block/character error modes, overrun, watchdog,
// multidrop wake-up, and the small transmitter that sends the A/D bit.
// Assumes bit clocks and serial line are synchronous to sys_clk_i.
//
// How it works
// R1: Queue holds eight characters; each finished character goes to next free slot.
// R2: Character-available is high while the queue holds one or more characters.
// R3: Full flag is high exactly when all eight slots are occupied.
// R4: Fill count is 3 bits, equals occupancy, saturates at seven.
// R5: Fill count is driven out continuously for interrupt bidding.
// R6: Queue read returns oldest character, then drops it with its status.
// R7: Each entry carries parity error, framing error and break bits.
// R8: Character mode reports only the head entry status bits.
// R9: Block mode reports OR of head statuses since last error reset.
// R10: Status reads leave the queue alone; read status before data.
// R11: A character finished while full waits in the hold register.
// R12: New start while holding and full drops held character, sets overrun.
// R13: Watchdog enabled by mode zero bit 7, expires after 64 bit clocks.
// R14: Watchdog restarts on queue load and on host queue read.
// R15: Mode field value 11 selects multidrop wake-up mode.
// R16: Wake-up, receiver off: keep address characters, discard data characters.
// R17: Wake-up, receiver on: queue every character.
// R18: Wake-up stores the address/data bit in the parity error slot.
// R19: Framing, overrun and break detection work while enabled, and in wake-up mode also while disabled.
// R20: Wake-up transmit frame: start, data, address/data bit, stop bits.
// R21: Transmitted address/data bit comes from mode one bit 2.
// R22: Host changes address/data bit only while transmitter is idle.
// R23: Empty queue gives no receive bid.
// R24: Unused upper data bits of short characters are zero.
// R25: Receiver reset empties queue, clears hold, overrun, restarts watchdog.
// R26: Watchdog timeout stays until restart, masked when disabled.
`timescale 1ns/100ps
module uart_rx_fifo_wakeup
  import uart_rx_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
) (
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       clk_en_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_en_i,
  input  wire logic       rd_en_i,
  output logic      [7:0] rd_data_o,
  input  wire logic       rx_bit_clock_i,
  input  wire logic       rx_line_i,
  input  wire logic       tx_bit_clock_i,
  output logic            tx_line_o,
  output logic            tx_idle_flag_o,
  output logic            rx_char_available_o,
  output logic            rx_queue_full_o,
  output logic      [2:0] rx_fill_count_o,
  output logic            rx_bid_o,
  output logic            watchdog_timeout_o
);

  localparam int AW = $clog2(DEPTH);

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_DATA   = 3'b001,
    RX_PARITY = 3'b010,
    RX_STOP   = 3'b011,
    RX_BREAK  = 3'b100
  } rx_state_t;

  typedef struct packed {
    logic [7:0]        mode_reg_zero;
    logic [7:0]        mode_reg_one;
    logic              rx_en;
    logic              tx_en;
    logic              rx_clk_prev;
    logic              tx_clk_prev;
    rx_state_t         rx_state;
    logic [2:0]        bit_idx;
    logic [7:0]        shift;
    logic              par_bit;
    logic              hold_valid;
    logic [ENTRY_W-1:0] hold;
    logic              overrun;
    logic [STAT_W-1:0] acc;
    logic              arrive;
    logic [6:0]        wd_cnt;
    logic              tx_hold_valid;
    logic [7:0]        tx_hold;
    logic [7:0]        rdata;
  } chan_state_t;

  chan_state_t        st_q;
  chan_state_t        st_d;
  logic               rx_tick;
  logic               tx_tick;
  logic [1:0]         par_mode;
  logic               wake_mode;
  logic               parity_on;
  logic [2:0]         last_bit;
  logic [ENTRY_W-1:0] q_head;
  logic [AW:0]        q_count;
  logic               q_empty;
  logic               q_full;
  logic               q_push;
  logic               q_pop;
  logic               q_clear;
  logic               accept;
  logic               tx_busy;
  logic               tx_load;
  logic               tx_par;
  logic [7:0]         tx_mask;
  logic [STAT_W-1:0]  head_stat;
  logic [7:0]         channel_status_reg;
  logic               wd_pending;
  logic               cmd_wr;

  assign rx_tick   = rx_bit_clock_i && !st_q.rx_clk_prev;
  assign tx_tick   = tx_bit_clock_i && !st_q.tx_clk_prev;
  assign par_mode  = st_q.mode_reg_one[MR1_MODE_HI:MR1_MODE_LO];
  // R15: wake-up select
  assign wake_mode = (par_mode == PAR_WAKE);
  assign parity_on = (par_mode != PAR_NONE);
  assign last_bit  = 3'h4 + {1'b0, st_q.mode_reg_one[MR1_BITS_HI:0]};
  assign cmd_wr    = wr_en_i && (addr_i == OFS_CMD);

  //////////////////////////////////////////////////////////////////////////////
  // Hold register to queue transfer

  // R16: address characters kept, data dropped while disabled
  // R17: all characters kept while enabled
  assign accept  = !(wake_mode && !st_q.rx_en && !st_q.hold[DATA_W + ST_PAR]);
  // R11: character waits in hold until a slot frees
  assign q_push  = st_q.hold_valid && !q_full && accept;
  // R6: pop after the read of the head
  assign q_pop   = rd_en_i && (addr_i == OFS_QUEUE) && !q_empty;
  // R25: receiver reset empties the queue
  assign q_clear = cmd_wr && wr_data_i[CMD_RX_RST];

  // R1: eight-entry queue
  uart_rx_queue #(
    .DEPTH (DEPTH),
    .WIDTH (ENTRY_W)
  ) u_queue (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .clk_en_i    (clk_en_i),
    .clear_i     (q_clear),
    .push_i      (q_push),
    .push_data_i (st_q.hold),
    .pop_i       (q_pop),
    .head_o      (q_head),
    .count_o     (q_count),
    .empty_o     (q_empty),
    .full_o      (q_full)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter

  assign tx_load = st_q.tx_hold_valid && !tx_busy;
  assign tx_mask = 8'hFF >> (2'h3 - st_q.mode_reg_one[MR1_BITS_HI:0]);
  // R21: address/data bit taken from mode one, not from the data
  assign tx_par  = wake_mode ? st_q.mode_reg_one[MR1_PAR_AD]
                             : expected_parity(st_q.tx_hold & tx_mask, par_mode,
                                               st_q.mode_reg_one[MR1_PAR_AD]);

  // R20: frame carries the address/data bit in the parity slot
  uart_tx_serializer u_tx (
    .sys_clk_i    (sys_clk_i),
    .sys_rst_i    (sys_rst_i),
    .clk_en_i     (clk_en_i),
    .bit_tick_i   (tx_tick),
    .load_i       (tx_load),
    .data_i       (st_q.tx_hold),
    .data_bits_i  (st_q.mode_reg_one[MR1_BITS_HI:0]),
    .parity_on_i  (parity_on),
    .parity_bit_i (tx_par),
    .stop2_i      (st_q.mode_reg_zero[MR0_STOP2]),
    .busy_o       (tx_busy),
    .serial_o     (tx_line_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Status and outputs

  always_comb begin
    // R8: character mode shows only the head entry
    head_stat = q_empty ? '0 : q_head[ENTRY_W-1:DATA_W];
    // R9: block mode shows the accumulated OR
    if (st_q.mode_reg_one[MR1_ERR_MODE]) begin
      head_stat = st_q.acc;
    end
  end

  // R26: pending until restart, masked by the enable
  assign wd_pending = st_q.mode_reg_zero[MR0_WDOG_EN] && (st_q.wd_cnt == WDOG_LIMIT);

  always_comb begin
    channel_status_reg                          = '0;
    // R2: available while anything is queued
    channel_status_reg[SR_AVAIL]                = !q_empty;
    // R3: full at eight entries
    channel_status_reg[SR_FULL]                 = q_full;
    channel_status_reg[SR_TXRDY]                = !st_q.tx_hold_valid;
    channel_status_reg[SR_TXIDLE]               = !st_q.tx_hold_valid && !tx_busy;
    channel_status_reg[SR_OVERRUN]              = st_q.overrun;
    channel_status_reg[SR_PAR + STAT_W - 1:SR_PAR] = head_stat;
  end

  assign rx_char_available_o = !q_empty;
  assign rx_queue_full_o     = q_full;
  // R4: saturate at seven; full flag tells eight apart
  // R5: count driven continuously to the bidding logic
  assign rx_fill_count_o     = q_full ? 3'h7 : q_count[2:0];
  // R23: no bid while empty
  assign rx_bid_o            = !q_empty;
  assign watchdog_timeout_o  = wd_pending;
  assign tx_idle_flag_o      = channel_status_reg[SR_TXIDLE];
  assign rd_data_o           = st_q.rdata;

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d             = st_q;
    st_d.rx_clk_prev = rx_bit_clock_i;
    st_d.tx_clk_prev = tx_bit_clock_i;
    st_d.rdata       = '0;

    // Register reads; R10: status read has no side effect
    if (rd_en_i) begin
      case (addr_i)
        OFS_QUEUE:  st_d.rdata = q_empty ? 8'h00 : q_head[DATA_W-1:0];
        OFS_STATUS: st_d.rdata = channel_status_reg;
        OFS_MR0:    st_d.rdata = st_q.mode_reg_zero;
        OFS_MR1:    st_d.rdata = st_q.mode_reg_one;
        OFS_AUX:    st_d.rdata = {3'h0, wd_pending, q_full, rx_fill_count_o};
        default:    st_d.rdata = 8'h00;
      endcase
    end

    // Transmit hold drains into the serializer before new writes land
    if (tx_load) begin
      st_d.tx_hold_valid = 1'b0;
    end

    if (wr_en_i) begin
      case (addr_i)
        OFS_MR0: st_d.mode_reg_zero = wr_data_i;
        OFS_MR1: st_d.mode_reg_one = wr_data_i;
        OFS_QUEUE: begin
          if (st_q.tx_en && !st_q.tx_hold_valid) begin
            st_d.tx_hold_valid = 1'b1;
            st_d.tx_hold       = wr_data_i;
          end
        end
        OFS_CMD: begin
          if (wr_data_i[CMD_RX_EN]) begin
            st_d.rx_en = 1'b1;
          end
          if (wr_data_i[CMD_RX_DIS]) begin
            st_d.rx_en = 1'b0;
          end
          if (wr_data_i[CMD_TX_EN]) begin
            st_d.tx_en = 1'b1;
          end
          if (wr_data_i[CMD_TX_DIS]) begin
            st_d.tx_en = 1'b0;
          end
          // Clears first so a same-cycle error event still sets
          if (wr_data_i[CMD_ERR_RST]) begin
            st_d.acc     = '0;
            st_d.overrun = 1'b0;
          end
        end
        default: ;
      endcase
    end

    if (q_push || (st_q.hold_valid && !accept)) begin
      st_d.hold_valid = 1'b0;
    end

    // R9: fold in each entry one cycle after it reaches the head
    st_d.arrive = (q_pop && q_count > (AW+1)'(1)) || (q_push && (q_empty || q_pop));
    if (st_q.arrive && !q_empty) begin
      st_d.acc = st_d.acc | q_head[ENTRY_W-1:DATA_W];
    end

    // R13: count bit clocks up to the limit
    if (rx_tick && st_q.mode_reg_zero[MR0_WDOG_EN] && st_q.wd_cnt != WDOG_LIMIT) begin
      st_d.wd_cnt = st_q.wd_cnt + 7'h01;
    end
    // R14: restart on load or read
    if (q_push || (rd_en_i && addr_i == OFS_QUEUE)) begin
      st_d.wd_cnt = '0;
    end

    // R19: wake-up mode listens even while disabled
    if (rx_tick) begin
      unique case (st_q.rx_state)
        RX_IDLE: begin
          if ((st_q.rx_en || wake_mode) && !rx_line_i) begin
            st_d.rx_state = RX_DATA;
            st_d.bit_idx  = '0;
            // R24: upper bits of short characters stay zero
            st_d.shift    = '0;
            // R12: start bit while holding and full loses the held one
            if (st_q.hold_valid && q_full) begin
              st_d.hold_valid = 1'b0;
              st_d.overrun    = 1'b1;
            end
          end
        end
        RX_DATA: begin
          st_d.shift[st_q.bit_idx] = rx_line_i;
          st_d.bit_idx             = st_q.bit_idx + 3'h1;
          if (st_q.bit_idx == last_bit) begin
            st_d.rx_state = parity_on ? RX_PARITY : RX_STOP;
          end
        end
        RX_PARITY: begin
          st_d.par_bit  = rx_line_i;
          st_d.rx_state = RX_STOP;
        end
        RX_STOP: begin
          // R7: data plus three status bits per entry
          st_d.hold_valid                = 1'b1;
          st_d.hold[DATA_W-1:0]          = st_q.shift;
          st_d.hold[DATA_W + ST_FRAME]   = !rx_line_i;
          st_d.hold[DATA_W + ST_BRK]     = (st_q.shift == 8'h00) && !rx_line_i &&
                                           !(parity_on && st_q.par_bit);
          // R18: address/data bit goes into the parity slot
          st_d.hold[DATA_W + ST_PAR]     = wake_mode ? st_q.par_bit :
                                           parity_on && (st_q.par_bit != expected_parity(
                                             st_q.shift, par_mode, st_q.mode_reg_one[MR1_PAR_AD]));
          // A break loads one zero character, then waits for the line to rise
          st_d.rx_state = st_d.hold[DATA_W + ST_BRK] ? RX_BREAK : RX_IDLE;
        end
        RX_BREAK: begin
          if (rx_line_i) begin
            st_d.rx_state = RX_IDLE;
          end
        end
        default: st_d.rx_state = RX_IDLE;
      endcase
    end

    // R25: receiver reset wins over every receive event
    if (q_clear) begin
      st_d.rx_state   = RX_IDLE;
      st_d.hold_valid = 1'b0;
      st_d.overrun    = 1'b0;
      st_d.arrive     = 1'b0;
      st_d.wd_cnt     = '0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q               <= '0;
      st_q.mode_reg_zero <= MR0_RST;
      st_q.mode_reg_one  <= MR1_RST;
      st_q.rx_state      <= RX_IDLE;
    end else if (clk_en_i) begin
      st_q <= st_d;
    end
  end

endmodule // uart_rx_fifo_wakeup

// ===== src/uart_rx_pkg.sv
// Constants, register map and shared helpers for the receive channel.
// Assumes a single system clock; all users import the whole package.
package uart_rx_pkg;

  localparam int QUEUE_DEPTH = 8;
  localparam int DATA_W      = 8;
  localparam int STAT_W      = 3;
  localparam int ENTRY_W     = DATA_W + STAT_W;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets on the plain register port
  localparam logic [2:0] OFS_QUEUE  = 3'h0;
  localparam logic [2:0] OFS_STATUS = 3'h1;
  localparam logic [2:0] OFS_MR0    = 3'h2;
  localparam logic [2:0] OFS_MR1    = 3'h3;
  localparam logic [2:0] OFS_CMD    = 3'h4;
  localparam logic [2:0] OFS_AUX    = 3'h5;

  localparam logic [7:0] MR0_RST = 8'h00;
  localparam logic [7:0] MR1_RST = 8'h00;

  // Mode register bit positions
  localparam int MR0_WDOG_EN  = 7;
  localparam int MR0_STOP2    = 0;
  localparam int MR1_ERR_MODE = 5;
  localparam int MR1_MODE_HI  = 4;
  localparam int MR1_MODE_LO  = 3;
  localparam int MR1_PAR_AD   = 2;
  localparam int MR1_BITS_HI  = 1;

  // Parity mode field codes
  localparam logic [1:0] PAR_WITH  = 2'h0;
  localparam logic [1:0] PAR_FORCE = 2'h1;
  localparam logic [1:0] PAR_NONE  = 2'h2;
  localparam logic [1:0] PAR_WAKE  = 2'h3;

  // Command register bits
  localparam int CMD_RX_EN   = 0;
  localparam int CMD_RX_DIS  = 1;
  localparam int CMD_TX_EN   = 2;
  localparam int CMD_TX_DIS  = 3;
  localparam int CMD_RX_RST  = 4;
  localparam int CMD_ERR_RST = 6;

  // Status register bits
  localparam int SR_AVAIL   = 0;
  localparam int SR_FULL    = 1;
  localparam int SR_TXRDY   = 2;
  localparam int SR_TXIDLE  = 3;
  localparam int SR_OVERRUN = 4;
  localparam int SR_PAR     = 5;

  // Per-entry status layout above the data byte
  localparam int ST_PAR   = 0;
  localparam int ST_FRAME = 1;
  localparam int ST_BRK   = 2;

  localparam int         WDOG_BITS  = 64;
  localparam logic [6:0] WDOG_LIMIT = 7'(WDOG_BITS);
  localparam logic [3:0] MIN_BITS   = 4'h5;

  // Expected parity bit for a character: forced value, or even/odd select
  function automatic logic expected_parity(input logic [7:0] d, input logic [1:0] mode,
                                           input logic sel);
    return (mode == PAR_FORCE) ? sel : ((^d) ^ sel);
  endfunction

endpackage

// ===== src/uart_rx_queue.sv
// Receive queue: pointer-addressed flip-flop storage with occupancy count.
// Assumes the owner never pushes while full; pop on empty is ignored.
`timescale 1ns/100ps
module uart_rx_queue
  import uart_rx_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int WIDTH = ENTRY_W,
  localparam int AW   = $clog2(DEPTH)
) (
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             clk_en_i,
  input  wire logic             clear_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] head_o,
  output logic      [AW:0]      count_o,
  output logic                  empty_o,
  output logic                  full_o
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } queue_state_t;

  queue_state_t st_q;
  queue_state_t st_d;
  logic         do_push;
  logic         do_pop;

  assign full_o  = (st_q.cnt == (AW+1)'(DEPTH));
  assign empty_o = (st_q.cnt == '0);
  assign do_push = push_i && !full_o;
  assign do_pop  = pop_i && !empty_o;
  assign head_o  = st_q.mem[st_q.rd];
  assign count_o = st_q.cnt;

  always_comb begin
    st_d = st_q;
    if (clear_i) begin
      st_d.wr  = '0;
      st_d.rd  = '0;
      st_d.cnt = '0;
    end else begin
      if (do_push) begin
        st_d.mem[st_q.wr] = push_data_i;
        st_d.wr           = st_q.wr + 1'b1;
      end
      if (do_pop) begin
        st_d.rd = st_q.rd + 1'b1;
      end
      if (do_push && !do_pop) begin
        st_d.cnt = st_q.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
        st_d.cnt = st_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else if (clk_en_i) begin
      st_q <= st_d;
    end
  end

endmodule // uart_rx_queue

// ===== src/uart_tx_serializer.sv
// Transmit serializer: start, 5..8 data bits LSB first, optional parity or
// address/data bit, one or two stop bits. One bit per bit_tick_i.
`timescale 1ns/100ps
module uart_tx_serializer
  import uart_rx_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       clk_en_i,
  input  wire logic       bit_tick_i,
  input  wire logic       load_i,
  input  wire logic [7:0] data_i,
  input  wire logic [1:0] data_bits_i,
  input  wire logic       parity_on_i,
  input  wire logic       parity_bit_i,
  input  wire logic       stop2_i,
  output logic            busy_o,
  output logic            serial_o
);

  typedef struct packed {
    logic        busy;
    logic [12:0] frame;
    logic [3:0]  left;
    logic        line;
  } tx_state_t;

  tx_state_t   st_q;
  tx_state_t   st_d;
  logic [11:0] built;
  logic [11:0] wide_data;
  logic [3:0]  nbits;

  assign wide_data = {4'h0, data_i};
  assign nbits     = MIN_BITS + {2'h0, data_bits_i};
  assign busy_o    = st_q.busy;
  assign serial_o  = st_q.line;

  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (4'(i) < nbits) begin
        built[i] = wide_data[i];
      end else if (4'(i) == nbits && parity_on_i) begin
        built[i] = parity_bit_i;
      end else begin
        built[i] = 1'b1;
      end
    end
  end

  always_comb begin
    st_d = st_q;
    if (!st_q.busy && load_i) begin
      st_d.busy  = 1'b1;
      st_d.frame = {built, 1'b0};
      st_d.left  = nbits + {3'h0, parity_on_i} + 4'h2 + {3'h0, stop2_i};
    end else if (st_q.busy && bit_tick_i) begin
      if (st_q.left != 4'h0) begin
        st_d.line  = st_q.frame[0];
        st_d.frame = {1'b1, st_q.frame[12:1]};
        st_d.left  = st_q.left - 4'h1;
      end else begin
        st_d.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '{busy: 1'b0, frame: 13'h1FFF, left: 4'h0, line: 1'b1};
    end else if (clk_en_i) begin
      st_q <= st_d;
    end
  end

endmodule // uart_tx_serializer

// ===== verification/remote_station.sv
// Far-end station: free-running 1x bit clock and a frame sender.
// Assumes the receiver samples the line on rising bit clock edges.
`timescale 1ns/100ps
module remote_station (
  input  wire logic sys_clk_i,
  output logic      rx_bit_clock_o,
  output logic      rx_line_o
);
  logic [1:0] div_q = 2'h0;
  initial rx_line_o = 1'b1;
  // Baud clock runs free so the idle watchdog has edges to count
  always @(posedge sys_clk_i) div_q <= div_q + 2'h1;
  assign rx_bit_clock_o = div_q[1];
  task automatic send(input logic [7:0] d, input logic ad, input logic brk);
    logic [11:0] f;
    f = {1'b1, ~brk, ad, d, 1'b0};
    for (int i = 0; i < 12; i++) begin
      @(negedge rx_bit_clock_o);
      rx_line_o <= f[i];
    end
    @(negedge rx_bit_clock_o) #1;
  endtask
endmodule // remote_station

// ===== verification/testbench.sv
// Self-checking bench: register port master plus far-end station model.
// Assumes the package, design and checker bind are compiled first.
`timescale 1ns/100ps
module testbench;
  import uart_rx_pkg::*;
  logic       sys_clk_i, sys_rst_i, clk_en_i, wr_en_i, rd_en_i, tx_bit_clock_i;
  logic [2:0] addr_i;
  logic [7:0] wr_data_i, v;
  wire logic  rx_bit_clock_i, rx_line_i, tx_line_o, tx_idle_flag_o, rx_char_available_o;
  wire logic  rx_queue_full_o, rx_bid_o, watchdog_timeout_o;
  wire logic [7:0] rd_data_o;
  wire logic [2:0] rx_fill_count_o;
  int         n_fail = 0, num_checks = 0, cyc = 0, seed = 32'h68904665;
  logic [8:0] exp_q[$], c;
  logic [10:0] fr, e;
  uart_rx_fifo_wakeup uart_rx_fifo_wakeup_inst (.sys_clk_i, .sys_rst_i, .clk_en_i, .addr_i, .wr_data_i,
    .wr_en_i, .rd_en_i, .rd_data_o, .rx_bit_clock_i, .rx_line_i, .tx_bit_clock_i, .tx_line_o,
    .tx_idle_flag_o, .rx_char_available_o, .rx_queue_full_o, .rx_fill_count_o, .rx_bid_o,
    .watchdog_timeout_o);
  remote_station remote_station_inst (.sys_clk_i, .rx_bit_clock_o(rx_bit_clock_i), .rx_line_o(rx_line_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  ////////////////////////////////////////
  function automatic logic [7:0] lvl(input int n);
    return (n > 7) ? 8'h07 : 8'(n);
  endfunction
  function automatic logic [10:0] tx_frame(input logic [7:0] d, input logic ad);
    return {1'b1, ad, d, 1'b0};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    num_checks++;
    if (s !== x) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_en_i <= 1'b0;
    #1 d = rd_data_o;
  endtask
  task automatic get(input logic [8:0] x);
    logic [7:0] s;
    rd(OFS_STATUS, s);
    chk(s & 8'hE0, {2'h0, x[8], 5'h00});
    rd(OFS_QUEUE, s);
    chk(s, x[7:0]);
  endtask
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  initial begin
    {sys_rst_i, clk_en_i, addr_i, wr_data_i, wr_en_i, rd_en_i, tx_bit_clock_i} = {2'h3, 14'h0000};
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rd(OFS_MR0, v);
    chk(v, MR0_RST);
    rd(OFS_MR1, v);
    chk(v, MR1_RST);
    rd(3'h7, v);
    chk(v, 8'h00);
    wr(OFS_MR1, 8'h1B);
    wr(OFS_CMD, 8'h01);
    for (int i = 0; i < 10; i++) begin
      c = 9'($random(seed));
      remote_station_inst.send(c[7:0], c[8], 1'b0);
      if (i != 8) exp_q.push_back(c);
      chk({5'h0, rx_fill_count_o}, lvl(i + 1));
      chk({7'h0, rx_queue_full_o}, 8'(i >= 7));
    end
    rd(OFS_STATUS, v);
    chk(v & 8'h13, 8'h13);
    while (exp_q.size() > 0) get(exp_q.pop_front());
    chk({7'h0, rx_char_available_o}, 8'h00);
    wr(OFS_CMD, 8'h40);
    rd(OFS_STATUS, v);
    chk(v & 8'h10, 8'h00);
    wr(OFS_CMD, 8'h02);
    remote_station_inst.send(c[7:0], 1'b0, 1'b0);
    remote_station_inst.send(~c[7:0], 1'b1, 1'b0);
    chk({5'h0, rx_fill_count_o}, 8'h01);
    get({1'b1, ~c[7:0]});
    wr(OFS_MR1, 8'h3B);
    wr(OFS_CMD, 8'h01);
    remote_station_inst.send(8'h00, 1'b0, 1'b1);
    remote_station_inst.send(c[7:0], 1'b0, 1'b0);
    rd(OFS_STATUS, v);
    chk(v & 8'hC0, 8'hC0);
    rd(OFS_QUEUE, v);
    chk(v, 8'h00);
    rd(OFS_STATUS, v);
    chk(v & 8'hC0, 8'hC0);
    rd(OFS_QUEUE, v);
    chk(v, c[7:0]);
    wr(OFS_CMD, 8'h40);
    rd(OFS_STATUS, v);
    chk(v & 8'hE0, 8'h00);
    wr(OFS_MR1, 8'h38);
    wr(OFS_MR0, 8'h80);
    remote_station_inst.send(8'hFF, 1'b1, 1'b0);
    repeat (60) @(posedge rx_bit_clock_i);
    #1 chk({7'h0, watchdog_timeout_o}, 8'h00);
    @(posedge rx_bit_clock_i);
    #1 chk({7'h0, watchdog_timeout_o}, 8'h01);
    rd(OFS_QUEUE, v);
    chk(v, 8'h1F);
    chk({7'h0, watchdog_timeout_o}, 8'h00);
    remote_station_inst.send(8'hFF, 1'b1, 1'b0);
    wr(OFS_CMD, 8'h10);
    rd(OFS_AUX, v);
    chk(v, 8'h00);
    wr(OFS_CMD, 8'h04);
    wr(OFS_MR1, 8'h1F);
    wr(OFS_QUEUE, c[7:0]);
    repeat (3) @(posedge sys_clk_i);
    for (int i = 0; i < 13; i++) begin
      tx_bit_clock_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      tx_bit_clock_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      if (i < 11) fr = {tx_line_o, fr[10:1]};
    end
    e = tx_frame(c[7:0], 1'b1);
    chk(fr[7:0], e[7:0]);
    chk({5'h0, fr[10:8]}, {5'h0, e[10:8]});
    #1 chk({7'h0, tx_idle_flag_o}, 8'h01);
    stop_test();
  end
endmodule // testbench

// ===== verification/uart_rx_fifo_wakeup_properties.sv
// Port-level checker for the receive channel, attached by bind.
// Assumes clk_en_i stays high whenever an antecedent fires.
`timescale 1ns/100ps
module uart_rx_fifo_wakeup_properties
  import uart_rx_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       clk_en_i,
  input wire logic [2:0] addr_i,
  input wire logic       rd_en_i,
  input wire logic [7:0] rd_data_o,
  input wire logic       rx_char_available_o,
  input wire logic       rx_queue_full_o,
  input wire logic [2:0] rx_fill_count_o,
  input wire logic       rx_bid_o,
  input wire logic       watchdog_timeout_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_qread; rd_en_i && clk_en_i && addr_i == OFS_QUEUE; endsequence
  sequence s_sread; rd_en_i && clk_en_i && addr_i == OFS_STATUS; endsequence
  ////////////////////////////////////////
  property p_avail; rx_char_available_o == (rx_fill_count_o != 3'h0); endproperty
  a_avail: assert property (p_avail) else $error("available flag off");
  property p_bid; rx_bid_o == rx_char_available_o; endproperty
  a_bid: assert property (p_bid) else $error("bid without data");
  property p_full; rx_queue_full_o |-> rx_fill_count_o == 3'h7; endproperty
  a_full: assert property (p_full) else $error("full but count not 7");
  property p_full_rise; $rose(rx_queue_full_o) |-> $past(rx_fill_count_o) == 3'h7; endproperty
  a_full_rise: assert property (p_full_rise) else $error("full before seven");
  property p_pop; s_qread ##0 rx_fill_count_o != 3'h0 |=> rx_fill_count_o <= $past(rx_fill_count_o); endproperty
  a_pop: assert property (p_pop) else $error("queue read did not pop");
  property p_empty_rd; s_qread ##0 !rx_char_available_o |=> rd_data_o == 8'h00; endproperty
  a_empty_rd: assert property (p_empty_rd) else $error("empty read not zero");
  property p_rd_idle; !rd_en_i |=> rd_data_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_stat; s_sread |=> rx_fill_count_o >= $past(rx_fill_count_o); endproperty
  a_stat: assert property (p_stat) else $error("status read popped");
  property p_wdog; s_qread |=> !watchdog_timeout_o [*2]; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog not restarted");
endmodule // uart_rx_fifo_wakeup_properties

bind uart_rx_fifo_wakeup uart_rx_fifo_wakeup_properties uart_rx_fifo_wakeup_properties_inst (
  .sys_clk_i, .sys_rst_i, .clk_en_i, .addr_i, .rd_en_i, .rd_data_o, .rx_char_available_o,
  .rx_queue_full_o, .rx_fill_count_o, .rx_bid_o, .watchdog_timeout_o);
